// ---- serial_out_pin_control.sv ----
`timescale 1ns/10ps
module serial_out_pin_control (
    input  wire logic        REF_CLK_IN,
    input  wire logic        ARST_N_IN,
    input  wire logic        HSEL_IN,
    input  wire logic [31:0] HADDR_IN,
    input  wire logic [1:0]  HTRANS_IN,
    input  wire logic        HWRITE_IN,
    input  wire logic [2:0]  HSIZE_IN,
    input  wire logic [31:0] HWDATA_IN,
    input  wire logic        HREADY_IN,
    output logic      [31:0] HRDATA_OUT,
    output logic             HREADYOUT_OUT,
    output logic             HRESP_OUT,
    input  wire logic        BUS_SELECT_IN,
    input  wire logic        SERIAL_CLOCK_LINE_IN,
    input  wire logic [1:0]  BUS_MODE_IN,
    input  wire logic        READ_DATA_BIT_IN,
    input  wire logic        COUNT_DONE_IN,
    input  wire logic        BIDIR_PORT_PIN_ONE_IN,
    input  wire logic        BIDIR_PORT_PIN_TWO_IN,
    input  wire logic        PORT_ONE_IS_OUTPUT_IN,
    input  wire logic        PORT_TWO_IS_OUTPUT_IN,
    output logic             SEROUT_OUT,
    output logic             SEROUT_OE_OUT,
    output logic             IRQ_OUT
);

    logic [outpin_pkg::SYNC_W-1:0]  sync1;
    logic [outpin_pkg::SYNC_W-1:0]  sync2;
    logic [outpin_pkg::SYNC_W-1:0]  sync3;
    logic [outpin_pkg::SYNC_W-1:0]  level;
    logic [outpin_pkg::SYNC_W-1:0]  level_q;
    logic [outpin_pkg::SYNC_W-1:0]  next_level;
    logic [outpin_pkg::SYNC_W-1:0]  pins;

    logic [outpin_pkg::FIELD_W-1:0] outpin_ctrl_field;
    logic [outpin_pkg::FIELD_W-1:0] next_outpin_ctrl_field;
    logic                           if_count_start_bit;
    logic                           next_if_count_start_bit;
    logic                           start_q;
    logic                           armed;
    logic                           next_armed;
    logic                           done_low;
    logic                           next_done_low;
    logic                           shift_bit;
    logic                           next_shift_bit;
    outpin_pkg::pin_mode_t          pin_mode;
    outpin_pkg::pin_mode_t          next_pin_mode;
    logic                           oe;
    logic                           next_oe;

    logic [outpin_pkg::EV_W-1:0]    status;
    logic [outpin_pkg::EV_W-1:0]    next_status;
    logic [outpin_pkg::EV_W-1:0]    mask;
    logic [outpin_pkg::EV_W-1:0]    next_mask;
    logic [outpin_pkg::EV_W-1:0]    events;
    logic                           irq;
    logic                           next_irq;

    logic                           dp_write;
    logic                           next_dp_write;
    logic [outpin_pkg::ADDR_BITS-1:0] dp_addr;
    logic [outpin_pkg::ADDR_BITS-1:0] next_dp_addr;
    logic [31:0]                    rdata;
    logic [31:0]                    next_rdata;

    logic                           bus_sel;
    logic                           sel_rise;
    logic                           sclk_fall;
    logic                           start_rise;
    logic                           monitor;
    logic                           addr_phase;
    logic                           mirror_level;
    logic                           mirror_is_out;

    assign pins = {BIDIR_PORT_PIN_TWO_IN, BIDIR_PORT_PIN_ONE_IN,
                   SERIAL_CLOCK_LINE_IN, BUS_SELECT_IN};

    always_comb begin
        next_level             = level;
        next_outpin_ctrl_field = outpin_ctrl_field;
        next_if_count_start_bit = if_count_start_bit;
        next_mask              = mask;
        next_status            = status;
        next_armed             = armed;
        next_done_low          = done_low;
        next_shift_bit         = shift_bit;
        next_pin_mode          = outpin_pkg::PIN_OPEN;
        next_oe                = 1'b0;
        next_dp_write          = 1'b0;
        next_dp_addr           = dp_addr;
        next_rdata             = 32'h0000_0000;
        mirror_level           = 1'b1;
        mirror_is_out          = 1'b1;

        // A pin change counts once stages two and three agree
        for (int i = 0; i < outpin_pkg::SYNC_W; i++) begin
            if (sync2[i] == sync3[i]) begin
                next_level[i] = sync3[i];
            end
        end

        bus_sel    = level[outpin_pkg::SYNC_SEL];
        sel_rise   = bus_sel & ~level_q[outpin_pkg::SYNC_SEL];
        sclk_fall  = ~level[outpin_pkg::SYNC_SCLK] & level_q[outpin_pkg::SYNC_SCLK];
        start_rise = if_count_start_bit & ~start_q;
        monitor    = (outpin_ctrl_field == outpin_pkg::CTRL_DONE_MON);

        // Count completion monitor; a finishing count wins over a clear
        if (start_rise && monitor) begin
            next_armed    = 1'b1;
            next_done_low = 1'b0;
        end
        if (sel_rise) begin
            next_done_low = 1'b0;
        end
        if (COUNT_DONE_IN && armed && monitor) begin
            next_armed    = 1'b0;
            next_done_low = 1'b1;
        end
        if (!monitor) begin
            next_armed    = 1'b0;
            next_done_low = 1'b0;
        end

        // Read data advances on the falling serial clock edge
        if (sel_rise || (bus_sel && sclk_fall)) begin
            next_shift_bit = READ_DATA_BIT_IN;
        end

        if (outpin_ctrl_field == outpin_pkg::CTRL_MIRROR_ONE) begin
            mirror_level  = level[outpin_pkg::SYNC_PORT1];
            mirror_is_out = PORT_ONE_IS_OUTPUT_IN;
        end else if (outpin_ctrl_field == outpin_pkg::CTRL_MIRROR_TWO) begin
            mirror_level  = level[outpin_pkg::SYNC_PORT2];
            mirror_is_out = PORT_TWO_IS_OUTPUT_IN;
        end

        // Bus activity overrides the control field
        if (bus_sel) begin
            if (BUS_MODE_IN == outpin_pkg::MODE_READ) begin
                next_pin_mode = outpin_pkg::PIN_SHIFT;
            end else begin
                next_pin_mode = outpin_pkg::PIN_OPEN;
            end
        end else if (monitor && next_done_low) begin
            next_pin_mode = outpin_pkg::PIN_LOW;
        end else if (!mirror_is_out) begin
            next_pin_mode = outpin_pkg::PIN_MIRROR;
        end else begin
            next_pin_mode = outpin_pkg::PIN_OPEN;
        end

        // Open is the low driver switched off, never a driven high
        unique case (next_pin_mode)
            outpin_pkg::PIN_OPEN:   next_oe = 1'b0;
            outpin_pkg::PIN_LOW:    next_oe = 1'b1;
            outpin_pkg::PIN_SHIFT:  next_oe = ~next_shift_bit;
            outpin_pkg::PIN_MIRROR: next_oe = ~mirror_level;
        endcase

        events                          = '0;
        events[outpin_pkg::EV_DONE]     = COUNT_DONE_IN & armed & monitor;
        events[outpin_pkg::EV_SEL_RISE] = sel_rise;
        events[outpin_pkg::EV_START]    = start_rise;

        // Data phase write; a new event wins over a write-one clear
        if (dp_write) begin
            unique case (dp_addr)
                outpin_pkg::CTRL_OFS: begin
                    next_outpin_ctrl_field =
                        HWDATA_IN[outpin_pkg::FIELD_LSB +: outpin_pkg::FIELD_W];
                    next_if_count_start_bit = HWDATA_IN[outpin_pkg::START_BIT];
                end
                outpin_pkg::STATUS_OFS: next_status = status & ~HWDATA_IN[outpin_pkg::EV_W-1:0];
                outpin_pkg::MASK_OFS:   next_mask = HWDATA_IN[outpin_pkg::EV_W-1:0];
                default: ;
            endcase
        end
        next_status = next_status | events;
        next_irq    = |(next_status & next_mask);

        // Address phase; read data is captured now for the next cycle
        addr_phase = HSEL_IN & HTRANS_IN[1] & HREADY_IN;
        if (addr_phase) begin
            next_dp_write = HWRITE_IN;
            next_dp_addr  = HADDR_IN[outpin_pkg::ADDR_BITS-1:0];
            if (!HWRITE_IN && HADDR_IN[31:outpin_pkg::ADDR_BITS] == '0) begin
                unique case (HADDR_IN[outpin_pkg::ADDR_BITS-1:0])
                    outpin_pkg::CTRL_OFS: begin
                        next_rdata[outpin_pkg::FIELD_LSB +: outpin_pkg::FIELD_W] =
                            outpin_ctrl_field;
                        next_rdata[outpin_pkg::START_BIT] = if_count_start_bit;
                    end
                    outpin_pkg::STATUS_OFS: next_rdata[outpin_pkg::EV_W-1:0] = status;
                    outpin_pkg::MASK_OFS:   next_rdata[outpin_pkg::EV_W-1:0] = mask;
                    outpin_pkg::STATE_OFS: begin
                        next_rdata[1:0] = pin_mode;
                        next_rdata[2]   = oe;
                        next_rdata[3]   = armed;
                        next_rdata[4]   = done_low;
                        next_rdata[5]   = bus_sel;
                    end
                    default: ;
                endcase
            end
            if (HADDR_IN[31:outpin_pkg::ADDR_BITS] != '0) begin
                next_dp_write = 1'b0;
            end
        end
        // Hazard avoided: HSIZE ignored, only word access defined; nonzero addr[1:0] hits no register
        if (HSIZE_IN != 3'h2) begin
            next_dp_write = next_dp_write & 1'b1;
        end
    end

    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            sync1              <= '0;
            sync2              <= '0;
            sync3              <= '0;
            level              <= '0;
            level_q            <= '0;
            outpin_ctrl_field  <= outpin_pkg::CTRL_RESET[outpin_pkg::FIELD_W-1:0];
            if_count_start_bit <= outpin_pkg::CTRL_RESET[outpin_pkg::START_BIT];
            start_q            <= 1'b0;
            armed              <= 1'b0;
            done_low           <= 1'b0;
            shift_bit          <= 1'b1;
            pin_mode           <= outpin_pkg::PIN_OPEN;
            oe                 <= 1'b0;
            status             <= '0;
            mask               <= outpin_pkg::MASK_RESET;
            irq                <= 1'b0;
            dp_write           <= 1'b0;
            dp_addr            <= '0;
            rdata              <= '0;
        end else begin
            sync1              <= pins;
            sync2              <= sync1;
            sync3              <= sync2;
            level              <= next_level;
            level_q            <= level;
            outpin_ctrl_field  <= next_outpin_ctrl_field;
            if_count_start_bit <= next_if_count_start_bit;
            start_q            <= if_count_start_bit;
            armed              <= next_armed;
            done_low           <= next_done_low;
            shift_bit          <= next_shift_bit;
            pin_mode           <= next_pin_mode;
            oe                 <= next_oe;
            status             <= next_status;
            mask               <= next_mask;
            irq                <= next_irq;
            dp_write           <= next_dp_write;
            dp_addr            <= next_dp_addr;
            rdata              <= next_rdata;
        end
    end

    // Pin output level is constant low; only the enable moves
    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            SEROUT_OUT    <= 1'b0;
            HREADYOUT_OUT <= 1'b0;
            HRESP_OUT     <= 1'b0;
        end else begin
            SEROUT_OUT    <= 1'b0;
            HREADYOUT_OUT <= 1'b1;
            HRESP_OUT     <= 1'b0;
        end
    end

    assign SEROUT_OE_OUT = oe;
    assign IRQ_OUT       = irq;
    assign HRDATA_OUT    = rdata;

endmodule : serial_out_pin_control

// ---- outpin_pkg.sv ----
package outpin_pkg;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] MASK_OFS   = 8'h08;
    localparam logic [7:0] STATE_OFS  = 8'h0c;
    localparam int         ADDR_BITS  = 8;

    // Control register fields
    localparam int FIELD_LSB   = 0;
    localparam int FIELD_W     = 3;
    localparam int START_BIT   = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;

    // Status and mask bit positions
    localparam int EV_DONE     = 0;
    localparam int EV_SEL_RISE = 1;
    localparam int EV_START    = 2;
    localparam int EV_W        = 3;
    localparam logic [2:0] MASK_RESET = 3'h0;

    // Output pin control field encodings
    localparam logic [2:0] CTRL_OPEN       = 3'h0;
    localparam logic [2:0] CTRL_DONE_MON   = 3'h1;
    localparam logic [2:0] CTRL_MIRROR_ONE = 3'h2;
    localparam logic [2:0] CTRL_MIRROR_TWO = 3'h3;

    // Bus mode encodings from the serial framing logic
    localparam logic [1:0] MODE_WRITE_ONE = 2'h0;
    localparam logic [1:0] MODE_WRITE_TWO = 2'h1;
    localparam logic [1:0] MODE_READ      = 2'h2;

    // Pin synchroniser: select, clock, port one, port two
    localparam int SYNC_W     = 4;
    localparam int SYNC_SEL   = 0;
    localparam int SYNC_SCLK  = 1;
    localparam int SYNC_PORT1 = 2;
    localparam int SYNC_PORT2 = 3;

    typedef enum logic [1:0] {
        PIN_OPEN   = 2'b00,
        PIN_LOW    = 2'b01,
        PIN_SHIFT  = 2'b11,
        PIN_MIRROR = 2'b10
    } pin_mode_t;
endpackage : outpin_pkg

// ---- outpin_props.sv ----
`timescale 1ns/10ps
module outpin_props (
    input wire logic        REF_CLK_IN,
    input wire logic        ARST_N_IN,
    input wire logic        HSEL_IN,
    input wire logic [1:0]  HTRANS_IN,
    input wire logic        HREADY_IN,
    input wire logic [31:0] HRDATA_OUT,
    input wire logic        HREADYOUT_OUT,
    input wire logic        HRESP_OUT,
    input wire logic        BUS_SELECT_IN,
    input wire logic [1:0]  BUS_MODE_IN,
    input wire logic        COUNT_DONE_IN,
    input wire logic        BIDIR_PORT_PIN_ONE_IN,
    input wire logic        BIDIR_PORT_PIN_TWO_IN,
    input wire logic        SEROUT_OUT,
    input wire logic        SEROUT_OE_OUT
);
    default clocking cb @(posedge REF_CLK_IN);
    endclocking
    default disable iff (!ARST_N_IN);
    logic wr;
    assign wr = BUS_MODE_IN != outpin_pkg::MODE_READ;
    // Eight cycles covers the pin synchroniser plus the output flop
    sequence wr_held;
        (BUS_SELECT_IN && wr)[*8];
    endsequence
    sequence quiet;
        (!BUS_SELECT_IN && BIDIR_PORT_PIN_ONE_IN && BIDIR_PORT_PIN_TWO_IN)[*7];
    endsequence
    AST_NEVER_HIGH: assert property (SEROUT_OUT == 1'b0)
        else $error("serial pin data driven high");
    AST_RESET_OPEN: assert property ($rose(ARST_N_IN) |-> !SEROUT_OE_OUT[*2])
        else $error("pin not open after reset");
    AST_WRITE_OPEN: assert property (wr_held |-> !SEROUT_OE_OUT)
        else $error("pin pulled during write frame");
    AST_SEL_RISE_OPEN: assert property (!BUS_SELECT_IN ##1 wr_held |=> !SEROUT_OE_OUT)
        else $error("pin not released by bus select");
    AST_OE_CAUSE: assert property (quiet ##0 $rose(SEROUT_OE_OUT) |-> $past(COUNT_DONE_IN))
        else $error("pin pulled low without count done");
    AST_HREADY_UP: assert property (ARST_N_IN |=> HREADYOUT_OUT)
        else $error("bus not ready");
    AST_OKAY: assert property (HRESP_OUT == 1'b0)
        else $error("bus response not okay");
    AST_RDATA_IDLE: assert property (!(HSEL_IN && HTRANS_IN[1] && HREADY_IN) |=> HRDATA_OUT == 32'h0)
        else $error("read data outside data phase");
endmodule : outpin_props
bind serial_out_pin_control outpin_props u_props (.REF_CLK_IN(REF_CLK_IN),
    .ARST_N_IN(ARST_N_IN), .HSEL_IN(HSEL_IN), .HTRANS_IN(HTRANS_IN), .HREADY_IN(HREADY_IN),
    .HRDATA_OUT(HRDATA_OUT), .HREADYOUT_OUT(HREADYOUT_OUT), .HRESP_OUT(HRESP_OUT),
    .BUS_SELECT_IN(BUS_SELECT_IN), .BUS_MODE_IN(BUS_MODE_IN), .COUNT_DONE_IN(COUNT_DONE_IN),
    .BIDIR_PORT_PIN_ONE_IN(BIDIR_PORT_PIN_ONE_IN), .BIDIR_PORT_PIN_TWO_IN(BIDIR_PORT_PIN_TWO_IN),
    .SEROUT_OUT(SEROUT_OUT), .SEROUT_OE_OUT(SEROUT_OE_OUT));

// ---- ctrl_model.sv ----
`timescale 1ns/10ps
module ctrl_model #(
    parameter int HALF_NS = 24
) (
    input  wire logic       clk_in,
    output logic            sel_out,
    output logic            sclk_out,
    output logic      [1:0] mode_out
);
    logic run = 1'b0;
    // Serial clock stands still low outside frames
    initial begin
        sclk_out = 1'b0;
        forever begin
            #(HALF_NS);
            sclk_out = run ? ~sclk_out : 1'b0;
        end
    end
    // Select and mode have one driver: the caller of these tasks
    task automatic park();
        sel_out = 1'b0;
        mode_out = 2'h0;
    endtask : park
    task automatic open_frame(input logic [1:0] m);
        @(posedge clk_in);
        mode_out <= m;
        sel_out <= 1'b1;
        #(HALF_NS);
        run = 1'b1;
    endtask : open_frame
    task automatic close_frame();
        run = 1'b0;
        #(2 * HALF_NS);
        @(posedge clk_in);
        sel_out <= 1'b0;
    endtask : close_frame
endmodule : ctrl_model

// ---- tb_serial_out_pin_control.sv ----
`timescale 1ns/10ps
module tb_serial_out_pin_control;
    logic        clk, arst_n, hsel, hwrite, hready, hresp, cdone, rbit;
    logic        p1, p2, p1o, p2o, sel, sclk, oe, so, irq;
    logic [1:0]  htrans, mode;
    logic [31:0] haddr, hwdata, hrdata, rd;
    int          err_count = 0;
    int          n_compared = 0;
    ctrl_model host (.clk_in(clk), .sel_out(sel), .sclk_out(sclk), .mode_out(mode));
    serial_out_pin_control dut (.REF_CLK_IN(clk), .ARST_N_IN(arst_n), .HSEL_IN(hsel),
        .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2),
        .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready),
        .HRESP_OUT(hresp), .BUS_SELECT_IN(sel), .SERIAL_CLOCK_LINE_IN(sclk), .BUS_MODE_IN(mode),
        .READ_DATA_BIT_IN(rbit), .COUNT_DONE_IN(cdone), .BIDIR_PORT_PIN_ONE_IN(p1),
        .BIDIR_PORT_PIN_TWO_IN(p2), .PORT_ONE_IS_OUTPUT_IN(p1o), .PORT_TWO_IS_OUTPUT_IN(p2o),
        .SEROUT_OUT(so), .SEROUT_OE_OUT(oe), .IRQ_OUT(irq));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge clk); while (!hready && ++n < 50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (!hready && ++n < 50);
        rd = hrdata;
        if (n >= 50)
            err_count++;
    endtask : xfer
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(what, rd, exp);
    endtask : rd_chk
    // Pin inputs pass a synchroniser, so allow it to settle
    task automatic oe_chk(input logic exp);
        repeat (8) @(posedge clk);
        chk("pin_low", {31'h0, oe}, {31'h0, exp});
    endtask : oe_chk
    task automatic pulse();
        @(posedge clk);
        cdone <= 1'b1;
        @(posedge clk);
        cdone <= 1'b0;
    endtask : pulse
    task automatic do_reset();
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        oe_chk(1'b0);
        rd_chk("ctrl", outpin_pkg::CTRL_OFS, 32'h0);
    endtask : do_reset
    initial begin
        {arst_n, hsel, hwrite, cdone, p1o, p2o} = 6'h0;
        host.park();
        {rbit, p1, p2} = 3'h7;
        {htrans, haddr, hwdata} = 66'h0;
        do_reset();
        rd_chk("mask", outpin_pkg::MASK_OFS, 32'h0);
        xfer(1'b1, 8'h10, 32'hf);
        rd_chk("unmapped", 8'h10, 32'h0);
        xfer(1'b1, outpin_pkg::CTRL_OFS, 32'h1);
        pulse();
        oe_chk(1'b0);
        xfer(1'b1, outpin_pkg::CTRL_OFS, 32'h9);
        pulse();
        oe_chk(1'b1);
        rd_chk("status", outpin_pkg::STATUS_OFS, 32'h5);
        rd_chk("state", outpin_pkg::STATE_OFS, 32'h15);
        xfer(1'b1, outpin_pkg::MASK_OFS, 32'h1);
        // Irq is registered at the write's last edge
        @(posedge clk);
        chk("irq", {31'h0, irq}, 32'h1);
        xfer(1'b1, outpin_pkg::STATUS_OFS, 32'h1);
        @(posedge clk);
        chk("irq", {31'h0, irq}, 32'h0);
        xfer(1'b1, outpin_pkg::CTRL_OFS, 32'h1);
        xfer(1'b1, outpin_pkg::CTRL_OFS, 32'h9);
        oe_chk(1'b0);
        pulse();
        oe_chk(1'b1);
        host.open_frame(outpin_pkg::MODE_WRITE_ONE);
        oe_chk(1'b0);
        host.close_frame();
        oe_chk(1'b0);
        rd_chk("status", outpin_pkg::STATUS_OFS, 32'h7);
        xfer(1'b1, outpin_pkg::STATUS_OFS, 32'h7);
        rd_chk("status", outpin_pkg::STATUS_OFS, 32'h0);
        xfer(1'b1, outpin_pkg::CTRL_OFS, 32'h2);
        p1 <= 1'b0;
        oe_chk(1'b1);
        p1o <= 1'b1;
        oe_chk(1'b0);
        xfer(1'b1, outpin_pkg::CTRL_OFS, 32'h3);
        p2 <= 1'b0;
        oe_chk(1'b1);
        p2o <= 1'b1;
        oe_chk(1'b0);
        p2o <= 1'b0;
        // Mode code three is treated as a write mode
        for (int m = 0; m < 3; m++) begin
            host.open_frame(m == 2 ? 2'h3 : m[1:0]);
            oe_chk(1'b0);
            host.close_frame();
            oe_chk(1'b1);
        end
        xfer(1'b1, outpin_pkg::CTRL_OFS, 32'h4);
        oe_chk(1'b0);
        for (int b = 0; b < 2; b++) begin
            rbit <= b[0];
            host.open_frame(outpin_pkg::MODE_READ);
            repeat (20) @(posedge clk);
            chk("shift", {31'h0, oe}, {31'h0, ~b[0]});
            host.close_frame();
        end
        do_reset();
        print_verdict();
    end
    initial begin
        #100000;
        err_count++;
        print_verdict();
    end
endmodule : tb_serial_out_pin_control
